// ---- verilog/link_status_regs.svh ----
// Purpose: Constants for the link status code reporter
// Assumes: Status codes are 16 bits; requested states use 4-bit codes
// Notes:   Included by the main design file only
//
// What this block does
// - A request for a state change that the current state does not allow reports code 0x0011.
// - A request for a state value that is not known reports code 0x0012.
// - A request to enter the Bootstrap state is refused and reports code 0x0013.
// - A configuration memory that does not match the internal reference reports 0x0014 or 0x0020.
// - An invalid mailbox channel setting reports code 0x0016.
// - Consecutive receive failures above the configured threshold report code 0x001A.
// - Loss of the sync pulse while cyclic data runs reports code 0x001A.
// - Expiry of the process-data watchdog reports code 0x001B.
// - An invalid receive process-data channel setting reports code 0x001D.
// - An invalid transmit process-data channel setting reports code 0x001E.
// - An invalid process-data watchdog setting reports code 0x001F.
// - A node address that differs from the one of the previous run reports code 0x0021.
// - Bringing the link up after an address change without a power cycle reports code 0x0021.
// - These codes cover only communication faults and are the master's notice of the fault.
`ifndef LINK_STATUS_REGS_SVH
`define LINK_STATUS_REGS_SVH

`define CODE_NONE          16'h0000
`define CODE_ILLEGAL_TRANS 16'h0011
`define CODE_UNKNOWN_STATE 16'h0012
`define CODE_BOOT_REQ      16'h0013
`define CODE_VERIFY_WRITE  16'h0014
`define CODE_MBX_CFG       16'h0016
`define CODE_SYNC          16'h001A
`define CODE_PD_WDT        16'h001B
`define CODE_RXPD_CFG      16'h001D
`define CODE_TXPD_CFG      16'h001E
`define CODE_WDT_CFG       16'h001F
`define CODE_VERIFY_BOOT   16'h0020
`define CODE_ADDR_CHANGED  16'h0021

`define ST_INIT            4'h1
`define ST_PREOP           4'h2
`define ST_BOOT            4'h3
`define ST_SAFEOP          4'h4
`define ST_OP              4'h8

`define SYNC_TIMEOUT_CYC   4000

`endif

// ---- verilog/link_status_pkg.sv ----
// Purpose: Types shared by the link status code reporter
// Assumes: Nothing beyond the constants header
// Notes:   Fault sources are listed from highest to lowest priority
package link_status_pkg;

    typedef logic [15:0] al_code_t;

    typedef enum logic [3:0] {
        F_ILLEGAL,
        F_UNKNOWN,
        F_BOOT,
        F_VERIFY_W,
        F_VERIFY_B,
        F_MBX,
        F_RXPD,
        F_TXPD,
        F_WDTCFG,
        F_ADDR,
        F_RXCNT,
        F_SYNC,
        F_WDT,
        F_COUNT
    } fault_src_t;

endpackage

// ---- verilog/timeout_watch.sv ----
// Purpose: Counts cycles without a kick and flags expiry once
// Assumes: run, kick and limit come from the same clock domain
// Notes:   A limit of zero never expires
`timescale 1ns/100ps

module timeout_watch #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rstn,
    // Control
    input  wire logic         run,
    input  wire logic         kick,
    input  wire logic [W-1:0] limit,
    // Result
    output logic              expired_q
);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         fired_q;
    logic         fired_d;
    logic         expired_d;

    generate
        if (W < 2)
        begin : g_chk
            $error("timeout_watch needs W of at least 2");
        end
    endgenerate

    always_comb
    begin
        cnt_d     = cnt_q;
        fired_d   = fired_q;
        expired_d = 1'b0;
        if (!run || kick)
        begin
            cnt_d   = '0;
            fired_d = 1'b0;
        end
        else if (!fired_q && limit != '0)
        begin
            if (cnt_q >= limit - 1'b1)
            begin
                // One report per silence; a kick re-arms it
                expired_d = 1'b1;
                fired_d   = 1'b1;
            end
            else
            begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_q     <= '0;
            fired_q   <= 1'b0;
            expired_q <= 1'b0;
        end
        else
        begin
            cnt_q     <= cnt_d;
            fired_q   <= fired_d;
            expired_q <= expired_d;
        end
    end

    a_expire_single: assert property (@(posedge clk) disable iff (!rstn)
        expired_q |=> !expired_q)
        else $error("expiry pulsed twice in a row");

endmodule

// ---- verilog/link_status_code_reporter.sv ----
// Purpose: Picks the communication status code for the master
// Assumes: All inputs except sync_pin are on clk; check strobes are one-cycle pulses
// Notes:   Simultaneous faults resolve by fixed priority, transition faults first
`timescale 1ns/100ps
`include "link_status_regs.svh"

module link_status_code_reporter #(
    parameter int SYNC_TIMEOUT = `SYNC_TIMEOUT_CYC,
    parameter int CNT_W        = 8
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // State transition requests
    input  wire logic        trans_req,
    input  wire logic [3:0]  cur_state,
    input  wire logic [3:0]  req_state,
    // Channel configuration checks
    input  wire logic        mbx_chk,
    input  wire logic        mbx_ok,
    input  wire logic        rxpd_chk,
    input  wire logic        rxpd_ok,
    input  wire logic        txpd_chk,
    input  wire logic        txpd_ok,
    input  wire logic        wdt_chk,
    input  wire logic        wdt_ok,
    // Configuration memory compare
    input  wire logic        cfgmem_chk,
    input  wire logic        cfgmem_match,
    input  wire logic        cfgmem_at_boot,
    // Cyclic exchange
    input  wire logic        pd_active,
    input  wire logic        sync_pin,
    input  wire logic        rx_fail,
    input  wire logic        rx_good,
    input  wire logic [CNT_W-1:0] rx_fail_limit,
    input  wire logic        pd_frame,
    input  wire logic [15:0] wdt_limit,
    // Node address
    input  wire logic [15:0] node_addr,
    input  wire logic [15:0] prev_addr,
    input  wire logic        link_up,
    // Acknowledge
    input  wire logic        err_ack,
    // Report
    output link_status_pkg::al_code_t status_code_q,
    output logic             fault_q,
    output logic             code_new_q
);

    localparam logic [15:0] SYNC_LIMIT = 16'(SYNC_TIMEOUT);
    localparam int          NF         = int'(link_status_pkg::F_COUNT);

    generate
        if (SYNC_TIMEOUT < 2 || SYNC_TIMEOUT > 65535 || CNT_W < 2 || CNT_W > 16)
        begin : g_chk
            $error("link_status_code_reporter parameter out of range");
        end
    endgenerate

    // Known state values
    function automatic logic state_known(input logic [3:0] s);
        state_known = (s == `ST_INIT) || (s == `ST_PREOP) || (s == `ST_BOOT) ||
                      (s == `ST_SAFEOP) || (s == `ST_OP);
    endfunction

    // Permitted steps between operating states
    function automatic logic step_allowed(input logic [3:0] from, input logic [3:0] to);
        step_allowed = 1'b0;
        if (from == to)
            step_allowed = 1'b1;
        else if (to == `ST_INIT)
            step_allowed = (from != `ST_BOOT);
        else if (to == `ST_PREOP)
            step_allowed = (from == `ST_INIT) || (from == `ST_SAFEOP) || (from == `ST_OP);
        else if (to == `ST_SAFEOP)
            step_allowed = (from == `ST_PREOP) || (from == `ST_OP);
        else if (to == `ST_OP)
            step_allowed = (from == `ST_SAFEOP);
    endfunction

    // Code for each fault source
    function automatic link_status_pkg::al_code_t code_of(input link_status_pkg::fault_src_t f);
        case (f)
            link_status_pkg::F_ILLEGAL:  code_of = `CODE_ILLEGAL_TRANS;
            link_status_pkg::F_UNKNOWN:  code_of = `CODE_UNKNOWN_STATE;
            link_status_pkg::F_BOOT:     code_of = `CODE_BOOT_REQ;
            link_status_pkg::F_VERIFY_W: code_of = `CODE_VERIFY_WRITE;
            link_status_pkg::F_VERIFY_B: code_of = `CODE_VERIFY_BOOT;
            link_status_pkg::F_MBX:      code_of = `CODE_MBX_CFG;
            link_status_pkg::F_RXPD:     code_of = `CODE_RXPD_CFG;
            link_status_pkg::F_TXPD:     code_of = `CODE_TXPD_CFG;
            link_status_pkg::F_WDTCFG:   code_of = `CODE_WDT_CFG;
            link_status_pkg::F_ADDR:     code_of = `CODE_ADDR_CHANGED;
            link_status_pkg::F_RXCNT:    code_of = `CODE_SYNC;
            link_status_pkg::F_SYNC:     code_of = `CODE_SYNC;
            link_status_pkg::F_WDT:      code_of = `CODE_PD_WDT;
            default:                     code_of = `CODE_NONE;
        endcase
    endfunction

    // Sync pin crossing; sync_m2_q and its delayed copy sync_m3_q feed the edge detect
    logic sync_m1_q;
    logic sync_m2_q;
    logic sync_m3_q;
    logic sync_edge;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sync_m1_q <= 1'b0;
            sync_m2_q <= 1'b0;
            sync_m3_q <= 1'b0;
        end
        else
        begin
            sync_m1_q <= sync_pin;
            sync_m2_q <= sync_m1_q;
            sync_m3_q <= sync_m2_q;
        end
    end

    assign sync_edge = sync_m2_q && !sync_m3_q;

    logic sync_lost;

    timeout_watch #(
        .W (16)
    ) u_sync_watch (
        .clk       (clk),
        .rstn      (rstn),
        .run       (pd_active),
        .kick      (sync_edge),
        .limit     (SYNC_LIMIT),
        .expired_q (sync_lost)
    );

    logic wdt_expired;

    timeout_watch #(
        .W (16)
    ) u_pd_watchdog (
        .clk       (clk),
        .rstn      (rstn),
        .run       (pd_active),
        .kick      (pd_frame),
        .limit     (wdt_limit),
        .expired_q (wdt_expired)
    );

    // Receive failure count and power-up address capture
    logic [CNT_W-1:0] rxf_cnt_q;
    logic [CNT_W-1:0] rxf_cnt_d;
    logic             rxf_over;
    logic [15:0]      boot_addr_q;
    logic [15:0]      boot_addr_d;
    logic             cap_done_q;
    logic             cap_done_d;

    always_comb
    begin
        rxf_cnt_d   = rxf_cnt_q;
        rxf_over    = 1'b0;
        boot_addr_d = boot_addr_q;
        cap_done_d  = 1'b1;
        if (rx_good || !pd_active)
            rxf_cnt_d = '0;
        else if (rx_fail)
        begin
            if (rxf_cnt_q >= rx_fail_limit)
            begin
                rxf_over  = 1'b1;
                rxf_cnt_d = '0;
            end
            else
                rxf_cnt_d = rxf_cnt_q + 1'b1;
        end
        // Address is a strap caught after reset, not under it
        if (!cap_done_q)
            boot_addr_d = node_addr;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rxf_cnt_q   <= '0;
            boot_addr_q <= 16'h0000;
            cap_done_q  <= 1'b0;
        end
        else
        begin
            rxf_cnt_q   <= rxf_cnt_d;
            boot_addr_q <= boot_addr_d;
            cap_done_q  <= cap_done_d;
        end
    end

    // Fault detection
    logic [NF-1:0]  fault_vec;
    logic           known;

    always_comb
    begin
        fault_vec = '0;
        known     = state_known(req_state);
        fault_vec[link_status_pkg::F_UNKNOWN]  = trans_req && !known;
        fault_vec[link_status_pkg::F_BOOT]     = trans_req && (req_state == `ST_BOOT);
        fault_vec[link_status_pkg::F_ILLEGAL]  = trans_req && known && (req_state != `ST_BOOT) &&
                                                 !step_allowed(cur_state, req_state);
        fault_vec[link_status_pkg::F_VERIFY_W] = cfgmem_chk && !cfgmem_match && !cfgmem_at_boot;
        fault_vec[link_status_pkg::F_VERIFY_B] = cfgmem_chk && !cfgmem_match && cfgmem_at_boot;
        fault_vec[link_status_pkg::F_MBX]      = mbx_chk && !mbx_ok;
        fault_vec[link_status_pkg::F_RXPD]     = rxpd_chk && !rxpd_ok;
        fault_vec[link_status_pkg::F_TXPD]     = txpd_chk && !txpd_ok;
        fault_vec[link_status_pkg::F_WDTCFG]   = wdt_chk && !wdt_ok;
        fault_vec[link_status_pkg::F_ADDR]     = link_up && cap_done_q &&
                                                 ((node_addr != prev_addr) || (node_addr != boot_addr_q));
        fault_vec[link_status_pkg::F_RXCNT]    = rxf_over;
        fault_vec[link_status_pkg::F_SYNC]     = sync_lost;
        fault_vec[link_status_pkg::F_WDT]      = wdt_expired;
    end

    // Report register
    link_status_pkg::al_code_t code_d;
    link_status_pkg::al_code_t sel_code;
    logic                      fault_d;
    logic                      new_d;

    always_comb
    begin
        sel_code = `CODE_NONE;
        for (int i = NF - 1; i >= 0; i--)
        begin
            if (fault_vec[i])
                sel_code = code_of(link_status_pkg::fault_src_t'(i));
        end
        code_d  = status_code_q;
        fault_d = fault_q;
        new_d   = 1'b0;
        // new fault beats an acknowledge in the same cycle
        if (|fault_vec)
        begin
            code_d  = sel_code;
            fault_d = 1'b1;
            new_d   = 1'b1;
        end
        else if (err_ack)
        begin
            code_d  = `CODE_NONE;
            fault_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            status_code_q <= `CODE_NONE;
            fault_q       <= 1'b0;
            code_new_q    <= 1'b0;
        end
        else
        begin
            status_code_q <= code_d;
            fault_q       <= fault_d;
            code_new_q    <= new_d;
        end
    end

    // Checks
    sequence s_only(int b);
        fault_vec == (NF'(1) << b);
    endsequence

    property p_code(int b, logic [15:0] c);
        @(posedge clk) disable iff (!rstn)
        s_only(b) |=> (status_code_q == c) && fault_q && code_new_q;
    endproperty

    a_illegal_step: assert property (p_code(0, `CODE_ILLEGAL_TRANS))
        else $error("illegal step code wrong");
    a_unknown_state: assert property (p_code(1, `CODE_UNKNOWN_STATE))
        else $error("unknown state code wrong");
    a_boot_refused: assert property (@(posedge clk) disable iff (!rstn)
        trans_req && req_state == `ST_BOOT |=> status_code_q == `CODE_BOOT_REQ)
        else $error("bootstrap request not refused");
    a_verify_code: assert property (@(posedge clk) disable iff (!rstn)
        cfgmem_chk && !cfgmem_match && fault_vec[NF-1:5] == '0 && fault_vec[2:0] == '0
        |=> status_code_q == ($past(cfgmem_at_boot) ? `CODE_VERIFY_BOOT : `CODE_VERIFY_WRITE))
        else $error("verify code wrong");
    a_mbx_code: assert property (p_code(5, `CODE_MBX_CFG))
        else $error("mailbox code wrong");
    a_rxcnt_code: assert property (p_code(10, `CODE_SYNC))
        else $error("receive failure code wrong");
    a_sync_lost: assert property (@(posedge clk) disable iff (!rstn)
        $fell(sync_m2_q) && pd_active ##1 (!sync_m2_q && pd_active && fault_vec[8:0] == '0) [*3]
        |-> !sync_lost)
        else $error("sync loss flagged too early");
    a_sync_code: assert property (p_code(11, `CODE_SYNC))
        else $error("sync loss code wrong");
    a_wdt_code: assert property (p_code(12, `CODE_PD_WDT))
        else $error("watchdog code wrong");
    a_rxpd_code: assert property (p_code(6, `CODE_RXPD_CFG))
        else $error("receive channel code wrong");
    a_txpd_code: assert property (p_code(7, `CODE_TXPD_CFG))
        else $error("transmit channel code wrong");
    a_wdtcfg_code: assert property (p_code(8, `CODE_WDT_CFG))
        else $error("watchdog setting code wrong");
    a_addr_code: assert property (@(posedge clk) disable iff (!rstn)
        link_up && cap_done_q && node_addr != boot_addr_q && fault_vec[8:0] == '0
        |=> status_code_q == `CODE_ADDR_CHANGED)
        else $error("address change not reported");
    a_ack_clears: assert property (@(posedge clk) disable iff (!rstn)
        err_ack && fault_vec == '0 |=> status_code_q == `CODE_NONE && !fault_q && !code_new_q)
        else $error("acknowledge did not clear");

endmodule

// ---- tb/link_master_model.sv ----
// Purpose: Master side model that sends sync pulses and cyclic frames
// Assumes: Enables come from the bench on clk
// Notes:   The sync pin idles low between pulses, as a released pulse line does
`timescale 1ns/100ps

module link_master_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // Control
    input  wire logic sync_en,
    input  wire logic frame_en,
    // Cyclic outputs
    output logic      sync_pin,
    output logic      pd_frame
);
    int cnt;

    // no Boot request
    // Only cyclic traffic comes from here; the bench names Boot on purpose alone
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt      <= 0;
            sync_pin <= 1'b0;
            pd_frame <= 1'b0;
        end
        else
        begin
            cnt      <= (cnt == 9) ? 0 : cnt + 1;
            sync_pin <= sync_en && cnt < 2;
            pd_frame <= frame_en && (cnt % 5 == 0);
        end
    end
endmodule

// ---- tb/link_status_code_reporter_bench.sv ----
// Purpose: Self-checking bench for the link status code reporter
// Assumes: Sync timeout shortened to 20 cycles
// Notes:   Expected codes come from a small model kept in exp_code
`timescale 1ns/100ps

module link_status_code_reporter_bench;
    logic                      clk, rstn, sync_en, frame_en, sync_pin, pd_frame;
    logic                      trans_req, mbx_chk, rxpd_chk, txpd_chk, wdt_chk;
    logic                      mbx_ok, rxpd_ok, txpd_ok, wdt_ok;
    logic                      cfgmem_chk, cfgmem_match, cfgmem_at_boot;
    logic                      pd_active, rx_fail, rx_good, link_up, err_ack;
    logic [3:0]                cur_state, req_state;
    logic [7:0]                rx_fail_limit;
    logic [15:0]               wdt_limit, node_addr, prev_addr, exp_code, e;
    link_status_pkg::al_code_t status_code_q;
    logic                      fault_q, code_new_q;
    int                        bad_count, total_checks, lim;
    int                        states[4] = '{1, 2, 4, 8};
    logic [15:0]               cfg_codes[4] = '{16'h0016, 16'h001D, 16'h001E, 16'h001F};

    link_status_code_reporter #(.SYNC_TIMEOUT(20), .CNT_W(8)) dut (
        .clk(clk), .rstn(rstn), .trans_req(trans_req), .cur_state(cur_state),
        .req_state(req_state), .mbx_chk(mbx_chk), .mbx_ok(mbx_ok), .rxpd_chk(rxpd_chk),
        .rxpd_ok(rxpd_ok), .txpd_chk(txpd_chk), .txpd_ok(txpd_ok), .wdt_chk(wdt_chk),
        .wdt_ok(wdt_ok), .cfgmem_chk(cfgmem_chk), .cfgmem_match(cfgmem_match),
        .cfgmem_at_boot(cfgmem_at_boot), .pd_active(pd_active), .sync_pin(sync_pin),
        .rx_fail(rx_fail), .rx_good(rx_good), .rx_fail_limit(rx_fail_limit),
        .pd_frame(pd_frame), .wdt_limit(wdt_limit), .node_addr(node_addr),
        .prev_addr(prev_addr), .link_up(link_up), .err_ack(err_ack),
        .status_code_q(status_code_q), .fault_q(fault_q), .code_new_q(code_new_q));

    link_master_model master (.clk(clk), .rstn(rstn), .sync_en(sync_en),
        .frame_en(frame_en), .sync_pin(sync_pin), .pd_frame(pd_frame));

    always #12.5 clk = ~clk;

    task automatic cmp(input string what, input logic [15:0] x, input logic [15:0] g);
        total_checks++;
        if (g !== x)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, x, g);
        end
    endtask

    task automatic clr();
        {trans_req, mbx_chk, rxpd_chk, txpd_chk, wdt_chk} = '0;
        {cfgmem_chk, rx_fail, rx_good, link_up, err_ack} = '0;
    endtask

    // One edge takes the pulses, then one idle edge so no strobe is set twice in a step
    task automatic fire(input logic [15:0] x);
        @(negedge clk);
        clr();
        if (x != 16'h0000)
            exp_code = x;
        cmp("code", exp_code, status_code_q);
        cmp("fault", {15'h0, exp_code != 16'h0000}, {15'h0, fault_q});
        cmp("new", {15'h0, x != 16'h0000}, {15'h0, code_new_q});
        @(negedge clk);
    endtask

    // The acknowledge clears the code at the very edge that takes it
    task automatic ack();
        err_ack = 1'b1;
        exp_code = 16'h0000;
        fire(16'h0000);
        cmp("cleared", 16'h0000, status_code_q);
    endtask

    task automatic quiet(input int n);
        repeat (n)
        begin
            @(negedge clk);
            cmp("quiet", 16'h0000, {15'h0, code_new_q});
        end
    endtask

    // Watcher faults arrive after a count, so wait under a bound
    task automatic wait_new(input logic [15:0] x, input int n);
        int k;
        k = 0;
        while (code_new_q !== 1'b1 && k < n)
        begin
            @(negedge clk);
            k++;
        end
        exp_code = x;
        cmp("late code", x, status_code_q);
        cmp("in time", 16'h0001, {15'h0, code_new_q});
    endtask

    function automatic logic [15:0] trans_code(input int c, input int r);
        if (!(r inside {1, 2, 3, 4, 8}))
            return 16'h0012;
        if (r == 3)
            return 16'h0013;
        if (r == c || r == 1 || r == 2 || (r == 4 && c inside {2, 8}) || (r == 8 && c == 4))
            return 16'h0000;
        return 16'h0011;
    endfunction

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (6000) @(posedge clk);
        bad_count++;
        give_verdict();
    end

    initial
    begin
        void'($urandom(32'h6ebde647));
        clk = 1'b0;
        rstn = 1'b0;
        clr();
        {sync_en, frame_en, pd_active, cfgmem_match, cfgmem_at_boot} = '0;
        {mbx_ok, rxpd_ok, txpd_ok, wdt_ok} = 4'hF;
        {cur_state, req_state, rx_fail_limit, wdt_limit} = '0;
        node_addr = 16'($urandom);
        prev_addr = node_addr;
        exp_code = 16'h0000;
        repeat (8) @(negedge clk);
        cmp("reset", 16'h0000, {status_code_q[14:0], fault_q});
        rstn = 1'b1;
        repeat (2) @(negedge clk);
        foreach (states[i])
            for (int r = 0; r < 16; r++)
            begin
                cur_state = states[i][3:0];
                req_state = r[3:0];
                trans_req = 1'b1;
                e = trans_code(states[i], r);
                fire(e);
                ack();
            end
        for (int k = 0; k < 8; k++)
        begin
            {mbx_chk, rxpd_chk, txpd_chk, wdt_chk} = 4'b1000 >> (k / 2);
            {mbx_ok, rxpd_ok, txpd_ok, wdt_ok} = k[0] ? 4'hF : 4'h0;
            fire(k[0] ? 16'h0000 : cfg_codes[k / 2]);
            ack();
        end
        for (int k = 0; k < 3; k++)
        begin
            {cfgmem_chk, cfgmem_at_boot, cfgmem_match} = {1'b1, k[0], k[1]};
            fire(k == 2 ? 16'h0000 : (k == 1 ? 16'h0020 : 16'h0014));
            ack();
        end
        {mbx_chk, mbx_ok} = 2'b10;
        fire(16'h0016);
        {txpd_chk, txpd_ok, trans_req, cur_state, req_state} = {3'b101, 4'h1, 4'h8};
        fire(16'h0011);
        {err_ack, wdt_chk, wdt_ok} = 3'b110;
        fire(16'h001F);
        ack();
        lim = $urandom_range(4, 1);
        rx_fail_limit = lim[7:0];
        {pd_active, sync_en, wdt_ok} = 3'b111;
        repeat (lim)
        begin
            rx_fail = 1'b1;
            fire(16'h0000);
        end
        rx_good = 1'b1;
        fire(16'h0000);
        repeat (lim)
        begin
            rx_fail = 1'b1;
            fire(16'h0000);
        end
        rx_fail = 1'b1;
        fire(16'h001A);
        ack();
        quiet(40);
        sync_en = 1'b0;
        wait_new(16'h001A, 40);
        ack();
        sync_en = 1'b1;
        frame_en = 1'b1;
        wdt_limit = 16'($urandom_range(30, 15));
        quiet(60);
        frame_en = 1'b0;
        wait_new(16'h001B, 50);
        {pd_active, sync_en} = 2'b00;
        ack();
        link_up = 1'b1;
        fire(16'h0000);
        prev_addr = ~node_addr;
        link_up = 1'b1;
        fire(16'h0021);
        ack();
        prev_addr = node_addr + 16'h0001;
        node_addr = prev_addr;
        link_up = 1'b1;
        fire(16'h0021);
        ack();
        give_verdict();
    end
endmodule
